// *** utc_pkg.sv ***
// Constants for the serial port control-2 block
// Function
// - Transmit-empty enable requests interrupt on empty flag
// - Complete enable requests interrupt on complete flag
// - Receive enable requests interrupt on full flag
// - Idle enable requests interrupt on idle flag
// - Transmitter runs and owns pin while enabled
// - Single-wire direction bit steers shared pin
// - Re-enabling transmitter queues one idle character
// - Transmitter holds pin until queued traffic ends
// - Receiver disabled releases receive pin
// - Loop select releases receive pin
// - Writing standby bit parks receiver awaiting wakeup
// - Wake on idle line or address mark
// - Hardware clears standby bit on wakeup
// - Setting send-break queues one break character
// - Breaks repeat while set, ten or thirteen bits
// - A second break may be queued
// - Control register always accessible, resets to zero
// - Loop select feeds transmitter into receiver
// - Source select picks single-wire or internal loop
package utc_pkg;
    localparam int         ADDR_W      = 8;
    // Printed index is not word aligned; byte address is index times four
    localparam logic [5:0] IDX_CTRL2   = 6'h03;
    localparam logic [5:0] IDX_CFG     = 6'h04;
    localparam logic [5:0] IDX_IRQ_ST  = 6'h05;
    localparam logic [5:0] IDX_IRQ_MSK = 6'h06;
    localparam logic [5:0] IDX_STAT    = 6'h07;
    // Control-2 bit positions
    localparam int C2_TIE  = 7;
    localparam int C2_TX_COMPLETE_IRQ_EN = 6;
    localparam int C2_RIE  = 5;
    localparam int C2_IDLE_LINE_IRQ_EN = 4;
    localparam int C2_TE   = 3;
    localparam int C2_RE   = 2;
    localparam int C2_RWU  = 1;
    localparam int C2_SBK  = 0;
    // Line configuration bit positions
    localparam int CFG_LOOP_SELECT = 0;
    localparam int CFG_RX_SOURCE_SELECT  = 1;
    localparam int CFG_SINGLE_WIRE_DIRECTION = 2;
    localparam int CFG_LONG_BREAK_SELECT = 3;
    localparam int CFG_WAKE  = 4;
    localparam int CFG_W     = 5;
    // Event bit positions
    localparam int EV_TX_BUFFER_EMPTY_FLAG = 0;
    localparam int EV_TC   = 1;
    localparam int EV_RX_BUFFER_FULL_FLAG = 2;
    localparam int EV_IDLE = 3;
    localparam int EV_WAKE = 4;
    localparam int EV_BRK  = 5;
    localparam int EV_W    = 6;
    localparam logic [7:0]      CTRL2_RST = 8'h00;
    localparam logic [CFG_W-1:0] CFG_RST  = 5'h00;
    localparam logic [EV_W-1:0]  EV_RST   = 6'h00;
    localparam logic [3:0] BRK_BITS      = 4'hA;
    localparam logic [3:0] BRK_BITS_LONG = 4'hD;
    localparam logic [3:0] IDLE_BITS     = 4'hA;
    localparam int         BIT_DIV_DEF   = 16;
    typedef enum logic [1:0] {TS_IDLE, TS_PREAMBLE, TS_BREAK} utc_seq_t;
endpackage

// *** utc_ctrl2.sv ***
// Serial port control-2 register, break/idle sequencer and pin routing
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module utc_ctrl2 import utc_pkg::*; #(
    parameter int BIT_DIV = BIT_DIV_DEF
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Flags from the rest of the port
    input  wire logic              tx_buffer_empty_flag,
    input  wire logic              tx_complete_flag,
    input  wire logic              rx_buffer_full_flag,
    input  wire logic              idle_line_flag,
    // Data shifter and receiver status
    input  wire logic              tx_data_busy,
    input  wire logic              tx_data_bit,
    input  wire logic              rx_idle_detect,
    input  wire logic              rx_char_done,
    input  wire logic              rx_char_msb,
    // Pins
    input  wire logic              txd_i,
    input  wire logic              rxd_i,
    output logic                   txd_o,
    output logic                   txd_oe,
    // Control outputs
    output logic                   tx_enable_q,
    output logic                   rx_enable_q,
    output logic                   rx_standby_q,
    output logic                   rx_in_q,
    output logic                   tx_pin_claim_q,
    output logic                   rx_pin_claim_q,
    output logic                   irq_q
);

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] idx);
        return a == {idx, 2'b00};
    endfunction

    logic [7:0]       c2_q;
    logic [CFG_W-1:0] cfg_q;
    logic [EV_W-1:0]  st_q;
    logic [EV_W-1:0]  msk_q;
    logic [EV_W-1:0]  ev;
    logic [3:0]       prev_q;
    logic             brk_pend_q;
    logic             idle_pend_q;
    utc_seq_t         seq_q;
    logic [3:0]       bits_q;
    logic [15:0]      div_q;
    logic             bit_tick;
    logic             seq_end;
    logic             tx_active;
    logic             txd_d;
    logic             wr;
    logic             rd_setup;
    logic             mapped;
    logic             wr_c2;
    logic             wake;
    logic             brk_done;
    logic             start_brk;
    logic             start_idle;
    logic             loop_select;
    logic             rx_source_select;

    assign wr       = psel && penable && pwrite && pready;
    assign rd_setup = psel && !penable && !pwrite;
    assign mapped   = hit(paddr, IDX_CTRL2) || hit(paddr, IDX_CFG) || hit(paddr, IDX_IRQ_ST)
                      || hit(paddr, IDX_IRQ_MSK) || hit(paddr, IDX_STAT);
    assign wr_c2    = wr && hit(paddr, IDX_CTRL2);
    assign loop_select    = cfg_q[CFG_LOOP_SELECT];
    assign rx_source_select     = cfg_q[CFG_RX_SOURCE_SELECT];
    assign tx_active = tx_data_busy || (seq_q != TS_IDLE);

    // Zero-wait slave; read data is captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready <= 1'b1;
            if (psel && !penable) begin
                pslverr <= !mapped;
            end
            if (rd_setup) begin
                prdata <= 32'h0000_0000;
                if (hit(paddr, IDX_CTRL2)) begin
                    prdata <= {24'h00_0000, c2_q};
                end else if (hit(paddr, IDX_CFG)) begin
                    prdata <= {27'h000_0000, cfg_q};
                end else if (hit(paddr, IDX_IRQ_ST)) begin
                    prdata <= {26'h000_0000, st_q};
                end else if (hit(paddr, IDX_IRQ_MSK)) begin
                    prdata <= {26'h000_0000, msk_q};
                end else if (hit(paddr, IDX_STAT)) begin
                    prdata <= {24'h00_0000, tx_pin_claim_q, rx_pin_claim_q, seq_q,
                               brk_pend_q, idle_pend_q, tx_active, rx_standby_q};
                end
            end
        end
    end

    // Wakeup follows the selected method
    assign wake = c2_q[C2_RWU] && (cfg_q[CFG_WAKE] ? (rx_char_done && rx_char_msb)
                                                   : rx_idle_detect);

    // Control-2: software writes; hardware clears standby, a write of one wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c2_q <= CTRL2_RST;
        end else if (wr_c2) begin
            c2_q <= pwdata[7:0];
        end else if (wake) begin
            c2_q[C2_RWU] <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= CFG_RST;
            msk_q <= EV_RST;
        end else if (wr && hit(paddr, IDX_CFG)) begin
            cfg_q <= pwdata[CFG_W-1:0];
        end else if (wr && hit(paddr, IDX_IRQ_MSK)) begin
            msk_q <= pwdata[EV_W-1:0];
        end
    end

    // Queue requests; a new request in the start cycle is kept
    // A queued idle still leaves after the enable drops, else the pin is never freed
    assign start_brk  = (seq_q == TS_IDLE) && !tx_data_busy && brk_pend_q;
    assign start_idle = (seq_q == TS_IDLE) && !tx_data_busy && !brk_pend_q
                        && idle_pend_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brk_pend_q  <= 1'b0;
            idle_pend_q <= 1'b0;
        end else begin
            if (wr_c2 && pwdata[C2_SBK] && !c2_q[C2_SBK]) begin
                brk_pend_q <= 1'b1;
            end else if (start_brk) begin
                brk_pend_q <= 1'b0;
            end
            if (wr_c2 && pwdata[C2_TE] && !c2_q[C2_TE]) begin
                idle_pend_q <= 1'b1;
            end else if (start_idle) begin
                idle_pend_q <= 1'b0;
            end
        end
    end

    // Bit-time enable, runs only while a special character is on the line
    assign bit_tick = (seq_q != TS_IDLE) && (div_q == 16'(BIT_DIV - 1));
    assign seq_end  = bit_tick && (bits_q == 4'h1);
    assign brk_done = seq_end && (seq_q == TS_BREAK);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 16'h0000;
        end else if (seq_q == TS_IDLE || bit_tick) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    // Break and idle sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_q  <= TS_IDLE;
            bits_q <= 4'h0;
        end else begin
            unique case (seq_q)
                TS_IDLE: begin
                    if (start_brk) begin
                        seq_q  <= TS_BREAK;
                        bits_q <= cfg_q[CFG_LONG_BREAK_SELECT] ? BRK_BITS_LONG : BRK_BITS;
                    end else if (start_idle) begin
                        seq_q  <= TS_PREAMBLE;
                        bits_q <= IDLE_BITS;
                    end
                end
                TS_PREAMBLE: begin
                    if (seq_end) begin
                        seq_q <= TS_IDLE;
                    end else if (bit_tick) begin
                        bits_q <= bits_q - 4'h1;
                    end
                end
                TS_BREAK: begin
                    if (seq_end && c2_q[C2_SBK]) begin
                        bits_q <= cfg_q[CFG_LONG_BREAK_SELECT] ? BRK_BITS_LONG : BRK_BITS;
                    end else if (seq_end) begin
                        seq_q <= TS_IDLE;
                    end else if (bit_tick) begin
                        bits_q <= bits_q - 4'h1;
                    end
                end
                default: seq_q <= TS_IDLE;
            endcase
        end
    end

    always_comb begin
        unique case (seq_q)
            TS_BREAK:    txd_d = 1'b0;
            TS_PREAMBLE: txd_d = 1'b1;
            TS_IDLE:     txd_d = tx_data_busy ? tx_data_bit : 1'b1;
            default:     txd_d = 1'b1;
        endcase
    end

    // Pin ownership and routing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_o          <= 1'b1;
            txd_oe         <= 1'b0;
            tx_pin_claim_q <= 1'b0;
            rx_pin_claim_q <= 1'b0;
            rx_in_q        <= 1'b1;
            tx_enable_q    <= 1'b0;
            rx_enable_q    <= 1'b0;
            rx_standby_q   <= 1'b0;
        end else begin
            txd_o <= txd_d;
            // Keep the pin until all queued traffic has left
            tx_pin_claim_q <= c2_q[C2_TE] || tx_active || brk_pend_q || idle_pend_q;
            txd_oe <= (c2_q[C2_TE] || tx_active || brk_pend_q || idle_pend_q)
                      && (!(loop_select && rx_source_select) || cfg_q[CFG_SINGLE_WIRE_DIRECTION]);
            rx_pin_claim_q <= c2_q[C2_RE] && !loop_select;
            if (!loop_select) begin
                rx_in_q <= rxd_i;
            end else if (rx_source_select) begin
                rx_in_q <= txd_i;
            end else begin
                rx_in_q <= txd_d;
            end
            tx_enable_q  <= c2_q[C2_TE];
            rx_enable_q  <= c2_q[C2_RE];
            rx_standby_q <= c2_q[C2_RWU];
        end
    end

    // Edge events into sticky status, write one to clear, set wins
    assign ev = {brk_done, wake,
                 idle_line_flag && !prev_q[3], rx_buffer_full_flag && !prev_q[2],
                 tx_complete_flag && !prev_q[1], tx_buffer_empty_flag && !prev_q[0]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 4'h0;
            st_q   <= EV_RST;
        end else begin
            prev_q <= {idle_line_flag, rx_buffer_full_flag, tx_complete_flag,
                       tx_buffer_empty_flag};
            if (wr && hit(paddr, IDX_IRQ_ST)) begin
                st_q <= (st_q & ~pwdata[EV_W-1:0]) | ev;
            end else begin
                st_q <= st_q | ev;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (c2_q[C2_TIE] && tx_buffer_empty_flag)
                     || (c2_q[C2_TX_COMPLETE_IRQ_EN] && tx_complete_flag)
                     || (c2_q[C2_RIE] && rx_buffer_full_flag)
                     || (c2_q[C2_IDLE_LINE_IRQ_EN] && idle_line_flag)
                     || |(st_q & msk_q);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_tie;
        c2_q[C2_TIE] && tx_buffer_empty_flag |=> irq_q;
    endproperty
    a_tie: assert property (p_tie) else $error("empty irq missing");

    property p_tx_complete_irq_en;
        c2_q[C2_TX_COMPLETE_IRQ_EN] && tx_complete_flag |=> irq_q;
    endproperty
    a_tx_complete_irq_en: assert property (p_tx_complete_irq_en) else $error("complete irq missing");

    property p_rie;
        c2_q[C2_RIE] && rx_buffer_full_flag |=> irq_q;
    endproperty
    a_rie: assert property (p_rie) else $error("receive irq missing");

    property p_idle_line_irq_en;
        c2_q[C2_IDLE_LINE_IRQ_EN] && idle_line_flag |=> irq_q;
    endproperty
    a_idle_line_irq_en: assert property (p_idle_line_irq_en) else $error("idle irq missing");

    property p_noirq;
        c2_q[7:4] == 4'h0 && (st_q & msk_q) == EV_RST |=> !irq_q;
    endproperty
    a_noirq: assert property (p_noirq) else $error("spurious irq");

    property p_te_pin;
        c2_q[C2_TE] |=> tx_pin_claim_q && tx_enable_q;
    endproperty
    a_te_pin: assert property (p_te_pin) else $error("transmit pin not owned");

    property p_hold;
        !c2_q[C2_TE] && tx_active |=> tx_pin_claim_q;
    endproperty
    a_hold: assert property (p_hold) else $error("pin released early");

    property p_sw_dir;
        loop_select && rx_source_select && !cfg_q[CFG_SINGLE_WIRE_DIRECTION] |=> !txd_oe;
    endproperty
    a_sw_dir: assert property (p_sw_dir) else $error("single wire drives");

    property p_rx_rel;
        !c2_q[C2_RE] || loop_select |=> !rx_pin_claim_q;
    endproperty
    a_rx_rel: assert property (p_rx_rel) else $error("receive pin held");

    property p_loop;
        loop_select && !rx_source_select |=> rx_in_q == txd_o;
    endproperty
    a_loop: assert property (p_loop) else $error("loopback broken");

    property p_wake;
        wake && !wr_c2 |=> ##1 !rx_standby_q;
    endproperty
    a_wake: assert property (p_wake) else $error("standby not cleared");

    property p_brk_low;
        seq_q == TS_BREAK |=> !txd_o;
    endproperty
    a_brk_low: assert property (p_brk_low) else $error("break not low");

    property p_rd;
        rd_setup && hit(paddr, IDX_CTRL2) |=> prdata == {24'h00_0000, $past(c2_q)};
    endproperty
    a_rd: assert property (p_rd) else $error("control read wrong");

    property p_idle_hi;
        seq_q == TS_PREAMBLE |=> txd_o;
    endproperty
    a_idle_hi: assert property (p_idle_hi) else $error("idle char not high");

    property p_rx_own;
        c2_q[C2_RE] && !loop_select |=> rx_pin_claim_q && rx_enable_q;
    endproperty
    a_rx_own: assert property (p_rx_own) else $error("receive pin not owned");

    property p_sw_out;
        loop_select && rx_source_select && cfg_q[CFG_SINGLE_WIRE_DIRECTION] && c2_q[C2_TE] |=> txd_oe;
    endproperty
    a_sw_out: assert property (p_sw_out) else $error("single wire not driving");

    property p_sw_rx;
        loop_select && rx_source_select |=> rx_in_q == $past(txd_i);
    endproperty
    a_sw_rx: assert property (p_sw_rx) else $error("single wire rx broken");

    c_brk: cover property (seq_q == TS_BREAK ##1 seq_q == TS_IDLE);
    c_idle: cover property (start_idle);
    c_wake: cover property (wake ##1 !c2_q[C2_RWU]);
    c_brk_rep: cover property (seq_end && seq_q == TS_BREAK && c2_q[C2_SBK]);
    c_sw: cover property (loop_select && rx_source_select && txd_oe);

endmodule // utc_ctrl2

// *** utc_remote.sv ***
// Remote serial device model on the TxD/RxD line
`timescale 1ns/1ps
module utc_remote (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Line
    input  wire logic line_txd,
    input  wire logic send_bit,
    input  wire logic answer_bit,
    output logic      rxd,
    output logic      txd_drv,
    // Low-level run measurement
    output int        low_len,
    output int        low_runs
);
    int run_q;

    assign rxd     = send_bit;
    // Only seen on the shared wire while the port lets go of it
    assign txd_drv = answer_bit;

    // Back-to-back breaks may merge into one long low run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q    <= 0;
            low_len  <= 0;
            low_runs <= 0;
        end else if (!line_txd) begin
            run_q <= run_q + 1;
        end else begin
            if (run_q != 0) begin
                low_len  <= run_q;
                low_runs <= low_runs + 1;
            end
            run_q <= 0;
        end
    end
endmodule // utc_remote

// *** tb.sv ***
// Self-checking bench for the control-2 block
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin checks_done++; if ((sn) !== (ex)) begin miscompares++; \
    $display("CHECK FAILED %s exp %0h seen %0h", nm, ex, sn); end end
module tb;
    import utc_pkg::*;
    localparam int BD = 2;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, r;
    logic [3:0]        flags;
    logic              busy, tx_bit, idle_p, done_p, msb_p, send_bit, answer_bit;
    logic              rxd, txd_drv, txd_o, txd_oe, txd_pin, tx_en, rx_en, standby;
    logic              rx_in, tx_claim, rx_claim, irq;
    logic [7:0]        v;
    int                low_len, low_runs, b, seed_v, checks_done, miscompares;

    assign txd_pin = txd_oe ? txd_o : txd_drv;

    utc_ctrl2 #(.BIT_DIV(BD)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_buffer_empty_flag(flags[3]), .tx_complete_flag(flags[2]),
        .rx_buffer_full_flag(flags[1]), .idle_line_flag(flags[0]),
        .tx_data_busy(busy), .tx_data_bit(tx_bit), .rx_idle_detect(idle_p),
        .rx_char_done(done_p), .rx_char_msb(msb_p), .txd_i(txd_pin), .rxd_i(rxd),
        .txd_o(txd_o), .txd_oe(txd_oe), .tx_enable_q(tx_en), .rx_enable_q(rx_en),
        .rx_standby_q(standby), .rx_in_q(rx_in), .tx_pin_claim_q(tx_claim),
        .rx_pin_claim_q(rx_claim), .irq_q(irq));

    utc_remote i_remote (
        .pclk(pclk), .presetn(presetn), .line_txd(txd_pin), .send_bit(send_bit),
        .answer_bit(answer_bit), .rxd(rxd), .txd_drv(txd_drv), .low_len(low_len),
        .low_runs(low_runs));

    always #50 pclk = ~pclk;
    always @(posedge pclk) tx_bit <= 1'($urandom);

    function automatic logic irq_exp(input logic [3:0] en, input logic [3:0] fl);
        return |(en & fl);
    endfunction

    function automatic int brk_len(input int long_sel);
        return (long_sel != 0 ? 13 : 10) * BD;
    endfunction

    task automatic summarize();
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd_v);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            summarize();
        end
        rd_v = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] x;
        apb(1'b1, idx, {24'h0, d}, x);
    endtask

    task automatic rd(input logic [5:0] idx, output logic [31:0] rv);
        apb(1'b0, idx, 32'h0, rv);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic pulse(input logic idle_v, input logic done_v, input logic msb_v);
        @(posedge pclk);
        idle_p <= idle_v;
        done_p <= done_v;
        msb_p  <= msb_v;
        @(posedge pclk);
        idle_p <= 1'b0;
        done_p <= 1'b0;
        tick(3);
    endtask

    // Sequencer and pending requests all quiet
    task automatic wait_idle();
        logic [31:0] s;
        int n;
        n = 0;
        s = 32'h3C;
        while (s[5:2] !== 4'h0 && n < 300) begin
            rd(IDX_STAT, s);
            n++;
        end
        if (s[5:2] !== 4'h0) begin
            miscompares++;
            summarize();
        end
    endtask

    initial begin
        {pclk, presetn, psel, penable, pwrite, busy, idle_p, done_p, msb_p} = '0;
        {paddr, pwdata, flags} = '0;
        {send_bit, answer_bit} = 2'b11;
        checks_done = 0;
        miscompares = 0;
        seed_v = $urandom(11);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(IDX_CTRL2, r);
        `CHK("ctrl2 reset", {24'h0, CTRL2_RST}, r)
        rd(6'h10, r);
        `CHK("unmapped data", 32'h0, r)
        `CHK("unmapped err", 1'b1, last_err)
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom) & 8'hF4;
            wr(IDX_CTRL2, v);
            rd(IDX_CTRL2, r);
            `CHK("ctrl2 readback", {24'h0, v}, r)
            `CHK("rx claim", v[2], rx_claim)
            `CHK("rx enable", v[2], rx_en)
        end
        for (int i = 0; i < 10; i++) begin
            v = (i == 0) ? 8'h0F : (i == 1) ? 8'hFF : 8'($urandom);
            @(posedge pclk);
            flags <= v[3:0];
            wr(IDX_CTRL2, {v[7:4], 4'h0});
            tick(3);
            `CHK("irq level", irq_exp(v[7:4], v[3:0]), irq)
        end
        @(posedge pclk);
        flags <= 4'h0;
        wr(IDX_CTRL2, 8'h00);
        wr(IDX_IRQ_ST, 8'h3F);
        wr(IDX_IRQ_MSK, 8'h01);
        @(posedge pclk);
        flags <= 4'h8;
        @(posedge pclk);
        flags <= 4'h0;
        tick(3);
        `CHK("sticky irq", 1'b1, irq)
        wr(IDX_IRQ_MSK, 8'h00);
        tick(3);
        `CHK("masked irq", 1'b0, irq)
        wr(IDX_IRQ_MSK, 8'h01);
        wr(IDX_IRQ_ST, 8'h01);
        tick(3);
        `CHK("cleared irq", 1'b0, irq)
        for (int k = 0; k < 2; k++) begin
            wr(IDX_CFG, 8'(k << CFG_LONG_BREAK_SELECT));
            wr(IDX_CTRL2, 8'h08);
            wait_idle();
            b = low_runs;
            wr(IDX_CTRL2, 8'h09);
            wr(IDX_CTRL2, 8'h08);
            wait_idle();
            tick(2);
            `CHK("break count", b + 1, low_runs)
            `CHK("break length", brk_len(k), low_len)
        end
        b = low_runs;
        wr(IDX_CTRL2, 8'h09);
        tick(70);
        wr(IDX_CTRL2, 8'h08);
        wait_idle();
        tick(2);
        `CHK("held break", 1'b1, (low_runs - b >= 2) || (low_len >= 2 * brk_len(1)))
        wr(IDX_CFG, 8'h00);
        wr(IDX_CTRL2, 8'h00);
        wait_idle();
        @(posedge pclk);
        busy <= 1'b1;
        wr(IDX_CTRL2, 8'h08);
        tick(1);
        `CHK("tx drives pin", 1'b1, txd_oe)
        `CHK("tx enable", 1'b1, tx_en)
        rd(IDX_STAT, r);
        `CHK("idle queued", 1'b1, r[2])
        wr(IDX_CTRL2, 8'h00);
        tick(2);
        `CHK("pin kept", 1'b1, txd_oe)
        `CHK("claim kept", 1'b1, tx_claim)
        @(posedge pclk);
        busy <= 1'b0;
        wait_idle();
        tick(3);
        `CHK("pin freed", 1'b0, txd_oe)
        `CHK("claim freed", 1'b0, tx_claim)
        @(posedge pclk);
        send_bit <= 1'b0;
        wr(IDX_CTRL2, 8'h04);
        tick(3);
        `CHK("rx from pin", 1'b0, rx_in)
        `CHK("rx pin owned", 1'b1, rx_claim)
        wr(IDX_CFG, 8'h01);
        tick(3);
        `CHK("loop frees rx", 1'b0, rx_claim)
        `CHK("internal loop", 1'b1, rx_in)
        wr(IDX_CTRL2, 8'h05);
        tick(4);
        `CHK("loop break seen", 1'b0, rx_in)
        wr(IDX_CTRL2, 8'h04);
        wait_idle();
        @(posedge pclk);
        send_bit   <= 1'b1;
        answer_bit <= 1'b0;
        wr(IDX_CFG, 8'h03);
        tick(3);
        `CHK("single wire rx", 1'b0, rx_in)
        wr(IDX_CTRL2, 8'h0C);
        wr(IDX_CFG, 8'h07);
        tick(3);
        `CHK("dir out", 1'b1, txd_oe)
        wr(IDX_CFG, 8'h03);
        tick(3);
        `CHK("dir in", 1'b0, txd_oe)
        @(posedge pclk);
        answer_bit <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            wr(IDX_CFG, 8'(k << CFG_WAKE));
            wr(IDX_CTRL2, 8'h06);
            tick(2);
            `CHK("standby set", 1'b1, standby)
            pulse(k == 1, k == 0, 1'b1);
            `CHK("other wake ignored", 1'b1, standby)
            pulse(1'b0, k == 1, 1'b0);
            `CHK("msb low ignored", 1'b1, standby)
            pulse(k == 0, k == 1, 1'b1);
            `CHK("woken", 1'b0, standby)
            rd(IDX_CTRL2, r);
            `CHK("standby bit cleared", 1'b0, r[C2_RWU])
        end
        summarize();
    end
endmodule // tb
